// ==== common/sape_pkg.sv ====
// shared constants, command codes and slot policy table of the slot access policy engine
package sape_pkg;

   // ------------------------------------------------------------------
   // configuration zone layout
   // ------------------------------------------------------------------
   localparam int          NUM_SLOTS         = 16;
   localparam logic [6:0]  CFG_OFS_SPARE     = 7'h54;
   localparam logic [6:0]  CFG_OFS_LOCK_LO   = 7'h58;
   localparam logic [6:0]  CFG_OFS_LOCK_HI   = 7'h59;
   localparam logic [15:0] LOCK_FLAGS_RESET  = 16'hFFFF;
   localparam logic [7:0]  SPARE_RESET       = 8'h00;
   localparam int          CNT_WIDTH         = 21;
   localparam logic [20:0] CNT_MAX           = 21'h1F_FFFF;
   localparam int          AES_KEYS_PER_SLOT = 4;

   // ------------------------------------------------------------------
   // slots with a fixed role
   // ------------------------------------------------------------------
   localparam logic [3:0] SLOT_PRIMARY     = 4'h0;
   localparam logic [3:0] SLOT_INT_SIGN    = 4'h1;
   localparam logic [3:0] SLOT_IO_KEY      = 4'h6;
   localparam logic [3:0] SLOT_BOOT_DIGEST = 4'h7;
   localparam logic [3:0] SLOT_AES         = 4'h9;
   localparam logic [3:0] SLOT_DEV_CERT    = 4'hA;
   localparam logic [3:0] SLOT_SIGNER_PUB  = 4'hB;
   localparam logic [3:0] SLOT_SIGNER_CERT = 4'hC;
   localparam logic [3:0] SLOT_PARENT_PUB  = 4'hD;
   localparam logic [3:0] SLOT_VALIDATED   = 4'hE;
   localparam logic [3:0] SLOT_BOOT_PUB    = 4'hF;

   // ------------------------------------------------------------------
   // command modes
   // ------------------------------------------------------------------
   localparam logic [7:0] KEYGEN_MODE_PUBLIC  = 8'h00;
   localparam logic [7:0] KEYGEN_MODE_REGEN   = 8'h04;
   localparam logic [7:0] LOCK_MODE_SLOT      = 8'h02;
   localparam logic [7:0] VERIFY_MODE_VALID   = 8'h03;
   localparam logic [7:0] VERIFY_MODE_INVALID = 8'h07;

   typedef enum logic [3:0] {
      SAPE_OP_READ     = 4'h0,
      SAPE_OP_WRITE    = 4'h1,
      SAPE_OP_KEYGEN   = 4'h2,
      SAPE_OP_SIGN     = 4'h3,
      SAPE_OP_ECDH     = 4'h4,
      SAPE_OP_VERIFY   = 4'h5,
      SAPE_OP_LOCK     = 4'h6,
      SAPE_OP_COUNTER  = 4'h7,
      SAPE_OP_EXTRA    = 4'h8,
      SAPE_OP_BOOT     = 4'h9,
      SAPE_OP_KDF      = 4'hA,
      SAPE_OP_MAC      = 4'hB,
      SAPE_OP_CFG_READ = 4'hC
   } sape_op_t;

   typedef enum logic [1:0] {
      ST_OK      = 2'h0,
      ST_REFUSED = 2'h1,
      ST_FAILED  = 2'h2,
      ST_BAD_CMD = 2'h3
   } sape_status_t;

   // ------------------------------------------------------------------
   // per-slot policy word: key config in [31:16], slot config in [15:0]
   // ------------------------------------------------------------------
   localparam int SC_CLEAR_READ   = 0;
   localparam int SC_ALWAYS_WRITE = 1;
   localparam int SC_ENC_WRITE    = 2;
   localparam int SC_WKEY_LSB     = 8;
   localparam int KC_PRIVATE      = 16;
   localparam int KC_EXT_SIGN     = 17;
   localparam int KC_INT_SIGN     = 18;
   localparam int KC_ECDH         = 19;
   localparam int KC_UPDATABLE    = 20;
   localparam int KC_LOCKABLE_N   = 21;
   localparam int KC_VALIDATED    = 22;
   localparam int KC_AES          = 23;
   localparam int KC_BOOT_GATE    = 24;

   localparam logic [31:0] SLOT_POLICY [0:15] = '{
      32'h012B_0000, 32'h0025_0000, 32'h001B_0000, 32'h001B_0000,
      32'h001B_0000, 32'h0080_0604, 32'h0000_0002, 32'h0020_0000,
      32'h0000_0003, 32'h00A0_0002, 32'h0000_0003, 32'h0000_0003,
      32'h0000_0003, 32'h0000_0003, 32'h0060_0003, 32'h0000_0003
   };

endpackage : sape_pkg

// ==== src/sape_counter.sv ====
// saturating monotonic counter that only counts upward from zero
module sape_counter
   import sape_pkg::*;
#(
   parameter int                WIDTH = CNT_WIDTH,
   parameter logic [WIDTH-1:0]  MAX   = CNT_MAX
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             inc,
   output logic [WIDTH-1:0]      value,
   output logic                  at_max
);

   logic [WIDTH-1:0] next_value;

   // a request at the ceiling is dropped; the caller reports the failure
   always_comb begin
      next_value = value;
      if (inc && (value != MAX)) begin
         next_value = value + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         value <= '0;
      end else begin
         value <= next_value;
      end
   end

   assign at_max = (value == MAX);

endmodule : sape_counter

// ==== src/sape_slot_policy.sv ====
// decodes the four configuration bytes of one slot into access permissions
module sape_slot_policy
   import sape_pkg::*;
(
   input  wire logic [3:0]  slot,
   output logic             clear_read,
   output logic             always_write,
   output logic             enc_write,
   output logic [3:0]       write_key,
   output logic             is_private,
   output logic             ext_sign,
   output logic             int_sign,
   output logic             ecdh_use,
   output logic             updatable,
   output logic             lockable,
   output logic             validated_type,
   output logic             aes_dest,
   output logic             boot_gate
);

   logic [31:0] word;

   always_comb begin
      word           = SLOT_POLICY[slot];
      clear_read     = word[SC_CLEAR_READ];
      always_write   = word[SC_ALWAYS_WRITE];
      enc_write      = word[SC_ENC_WRITE];
      write_key      = word[SC_WKEY_LSB +: 4];
      is_private     = word[KC_PRIVATE];
      ext_sign       = word[KC_EXT_SIGN];
      int_sign       = word[KC_INT_SIGN];
      ecdh_use       = word[KC_ECDH];
      updatable      = word[KC_UPDATABLE];
      // the lockable flag is active when the configuration bit is zero
      lockable       = !word[KC_LOCKABLE_N];
      validated_type = word[KC_VALIDATED];
      aes_dest       = word[KC_AES];
      boot_gate      = word[KC_BOOT_GATE];
   end

endmodule : sape_slot_policy

// ==== src/sape_engine.sv ====
// slot access policy engine: judges each command against the slot policies
// How it works
// - spare byte at offset 84, updatable once
// - counters start zero, upward only, capped
// - counters reached only by counter command
// - slot policy from four configuration bytes
// - private key slots never read out
// - primary key permanent, sign and ECDH only
// - secondary keys regenerate with mode 0x04
// - lockable slots lock once, block regeneration
// - slot 1 signs internal messages only
// - mode 0x00 returns slot-0 public key
// - validated key: use after validate, write after invalidate
// - certificates in slots 10 and 12, signer 11
// - boot digest slot 7: no read, no write
// - secure boot checks with slot-15 key
// - primary key optionally needs completed secure boot
// - secret key slot takes encrypted writes only
// - key agreement and derivation may store AES keys
// - protected commands use I/O protection key
// - lock bytes 88-89 start ones, clear on lock
// - I/O protection key lives in slot 6
module sape_engine
   import sape_pkg::*;
#(
   parameter logic BOOT_GATES_PRIMARY = 1'b0,
   parameter int   AES_KEYS           = AES_KEYS_PER_SLOT
) (
   input  wire logic                        clk,
   input  wire logic                        reset_n,
   input  wire logic                        cmd_valid,
   input  wire logic [3:0]                  cmd_op,
   input  wire logic [7:0]                  cmd_mode,
   input  wire logic [3:0]                  cmd_slot,
   input  wire logic [7:0]                  cmd_arg,
   input  wire logic                        cmd_internal_msg,
   input  wire logic                        cmd_encrypted,
   input  wire logic [3:0]                  cmd_write_key,
   input  wire logic                        cmd_io_protect,
   input  wire logic                        cmd_aes_store,
   input  wire logic                        cmd_auth_ok,
   output logic                             resp_valid,
   output logic [1:0]                       resp_status,
   output logic [23:0]                      resp_data,
   output logic                             grant_valid,
   output logic [3:0]                       grant_op,
   output logic [3:0]                       grant_slot,
   output logic                             grant_pubkey_only,
   output logic                             grant_io_protect,
   output logic [3:0]                       io_key_slot,
   output logic                             aes_store,
   output logic [$clog2(AES_KEYS)-1:0]      aes_key_index,
   output logic [15:0]                      slot_locked_flags,
   output logic [7:0]                       spare_user_byte,
   output logic                             spare_byte_used,
   output logic                             boot_latch,
   output logic                             validated_ok
);

   localparam int AW = $clog2(AES_KEYS);

   // ------------------------------------------------------------------
   // slot policy and counters
   // ------------------------------------------------------------------
   sape_op_t         op;
   logic             p_clear_read;
   logic             p_always_write;
   logic             p_enc_write;
   logic [3:0]       p_write_key;
   logic             p_private;
   logic             p_ext_sign;
   logic             p_int_sign;
   logic             p_ecdh;
   logic             p_updatable;
   logic             p_lockable;
   logic             p_validated;
   logic             p_aes;
   logic             p_boot_gate;
   logic [1:0]       cnt_inc;
   logic [CNT_WIDTH-1:0] cnt_val [2];
   logic [1:0]       cnt_at_max;

   assign op = sape_op_t'(cmd_op);

   sape_slot_policy u_policy (
      .slot           (cmd_slot),
      .clear_read     (p_clear_read),
      .always_write   (p_always_write),
      .enc_write      (p_enc_write),
      .write_key      (p_write_key),
      .is_private     (p_private),
      .ext_sign       (p_ext_sign),
      .int_sign       (p_int_sign),
      .ecdh_use       (p_ecdh),
      .updatable      (p_updatable),
      .lockable       (p_lockable),
      .validated_type (p_validated),
      .aes_dest       (p_aes),
      .boot_gate      (p_boot_gate)
   );

   // counters stand apart from every slot and latch
   for (genvar i = 0; i < 2; i++) begin : g_cnt
      sape_counter #(
         .WIDTH (CNT_WIDTH),
         .MAX   (CNT_MAX)
      ) u_cnt (
         .clk     (clk),
         .reset_n (reset_n),
         .inc     (cnt_inc[i]),
         .value   (cnt_val[i]),
         .at_max  (cnt_at_max[i])
      );
   end

   // ------------------------------------------------------------------
   // command judgement
   // ------------------------------------------------------------------
   logic                 unlocked;
   logic                 key_ready;
   logic                 allow;
   logic                 protectable;
   logic                 next_resp_valid;
   logic [1:0]           next_resp_status;
   logic [23:0]          next_resp_data;
   logic                 next_grant_valid;
   logic                 next_pubkey_only;
   logic                 next_io_protect;
   logic                 next_aes_store;
   logic [15:0]          next_locked;
   logic [7:0]           next_spare;
   logic                 next_spare_used;
   logic                 next_boot_latch;
   logic                 next_validated_ok;

   always_comb begin
      unlocked          = slot_locked_flags[cmd_slot];
      // primary key may be held back until a secure boot has passed
      key_ready         = !(BOOT_GATES_PRIMARY && p_boot_gate && !boot_latch);
      allow             = 1'b0;
      protectable       = 1'b0;
      cnt_inc           = 2'b00;
      next_resp_valid   = cmd_valid;
      next_resp_status  = ST_OK;
      next_resp_data    = '0;
      next_pubkey_only  = 1'b0;
      next_aes_store    = 1'b0;
      next_locked       = slot_locked_flags;
      next_spare        = spare_user_byte;
      next_spare_used   = spare_byte_used;
      next_boot_latch   = boot_latch;
      next_validated_ok = validated_ok;
      if (cmd_valid) begin
         unique case (op)
            SAPE_OP_READ: begin
               // certificate and public slots read in the clear; keys never
               allow = p_clear_read && !p_private;
            end
            SAPE_OP_WRITE: begin
               if (!p_private && unlocked && !(p_validated && validated_ok)) begin
                  if (p_enc_write) begin
                     allow = cmd_encrypted && (cmd_write_key == p_write_key)
                             && (p_write_key == SLOT_IO_KEY);
                  end else begin
                     allow = p_always_write;
                  end
               end
            end
            SAPE_OP_KEYGEN: begin
               if (p_private && cmd_mode == KEYGEN_MODE_PUBLIC) begin
                  allow            = 1'b1;
                  next_pubkey_only = 1'b1;
               end else if (p_private && cmd_mode == KEYGEN_MODE_REGEN) begin
                  // permanent keys carry no updatable bit, so slot 0 falls out here
                  allow = p_updatable && unlocked;
               end
            end
            SAPE_OP_SIGN: begin
               allow = p_private && key_ready
                       && (p_ext_sign || (p_int_sign && cmd_internal_msg));
            end
            SAPE_OP_ECDH: begin
               allow       = p_private && p_ecdh && key_ready;
               protectable = 1'b1;
            end
            SAPE_OP_VERIFY: begin
               protectable = 1'b1;
               if (cmd_mode == VERIFY_MODE_VALID || cmd_mode == VERIFY_MODE_INVALID) begin
                  // parent must already be permanent before it can vouch
                  allow = p_validated && cmd_auth_ok
                          && (cmd_arg[3:0] == SLOT_PARENT_PUB)
                          && !slot_locked_flags[SLOT_PARENT_PUB];
                  if (allow) begin
                     next_validated_ok = (cmd_mode == VERIFY_MODE_VALID);
                  end
               end else begin
                  allow = !p_private && (!p_validated || validated_ok);
               end
            end
            SAPE_OP_LOCK: begin
               allow = (cmd_mode == LOCK_MODE_SLOT) && p_lockable && unlocked;
               if (allow) begin
                  next_locked[cmd_slot] = 1'b0;
               end
            end
            SAPE_OP_COUNTER: begin
               if (cmd_mode[0] && cnt_at_max[cmd_arg[0]]) begin
                  next_resp_status = ST_FAILED;
               end else begin
                  allow                   = 1'b1;
                  cnt_inc[cmd_arg[0]]     = cmd_mode[0];
                  next_resp_data[CNT_WIDTH-1:0] = cnt_val[cmd_arg[0]]
                     + {{(CNT_WIDTH-1){1'b0}}, cmd_mode[0]};
               end
            end
            SAPE_OP_EXTRA: begin
               allow = !spare_byte_used;
               if (allow) begin
                  next_spare      = cmd_arg;
                  next_spare_used = 1'b1;
               end
            end
            SAPE_OP_BOOT: begin
               allow       = (cmd_slot == SLOT_BOOT_PUB);
               protectable = 1'b1;
               if (allow && cmd_auth_ok) begin
                  next_boot_latch = 1'b1;
               end
            end
            SAPE_OP_KDF: begin
               allow       = !p_clear_read && !p_private;
               protectable = 1'b1;
            end
            SAPE_OP_MAC: begin
               allow = !p_private && !p_clear_read;
            end
            SAPE_OP_CFG_READ: begin
               allow = 1'b1;
               unique case (cmd_arg[6:0])
                  CFG_OFS_SPARE:   next_resp_data[7:0] = spare_user_byte;
                  CFG_OFS_LOCK_LO: next_resp_data[7:0] = slot_locked_flags[7:0];
                  CFG_OFS_LOCK_HI: next_resp_data[7:0] = slot_locked_flags[15:8];
                  default:         next_resp_data[7:0] = 8'h00;
               endcase
            end
            default: next_resp_status = ST_BAD_CMD;
         endcase
         if (!allow && next_resp_status == ST_OK) begin
            next_resp_status = ST_REFUSED;
         end
         // derived keys land in the AES slot, one of several positions
         next_aes_store = allow && cmd_aes_store && SLOT_POLICY[SLOT_AES][KC_AES]
                          && (op == SAPE_OP_ECDH || op == SAPE_OP_KDF);
      end
      next_grant_valid = cmd_valid && allow;
      next_io_protect  = next_grant_valid && protectable && cmd_io_protect;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         resp_valid        <= 1'b0;
         resp_status       <= ST_OK;
         resp_data         <= '0;
         grant_valid       <= 1'b0;
         grant_op          <= 4'h0;
         grant_slot        <= 4'h0;
         grant_pubkey_only <= 1'b0;
         grant_io_protect  <= 1'b0;
         io_key_slot       <= SLOT_IO_KEY;
         aes_store         <= 1'b0;
         aes_key_index     <= '0;
         slot_locked_flags <= LOCK_FLAGS_RESET;
         spare_user_byte   <= SPARE_RESET;
         spare_byte_used   <= 1'b0;
         boot_latch        <= 1'b0;
         validated_ok      <= 1'b0;
      end else begin
         resp_valid        <= next_resp_valid;
         resp_status       <= next_resp_status;
         resp_data         <= next_resp_data;
         grant_valid       <= next_grant_valid;
         grant_op          <= cmd_op;
         grant_slot        <= (op == SAPE_OP_ECDH || op == SAPE_OP_KDF) && cmd_aes_store
                              ? SLOT_AES : cmd_slot;
         grant_pubkey_only <= next_pubkey_only;
         grant_io_protect  <= next_io_protect;
         io_key_slot       <= SLOT_IO_KEY;
         aes_store         <= next_aes_store;
         aes_key_index     <= cmd_arg[AW-1:0];
         slot_locked_flags <= next_locked;
         spare_user_byte   <= next_spare;
         spare_byte_used   <= next_spare_used;
         boot_latch        <= next_boot_latch;
         validated_ok      <= next_validated_ok;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   spare_once_a: assert property (spare_byte_used |=> $stable(spare_user_byte))
      else $error("spare byte changed after its single update");
   cnt_rise_a: assert property (cnt_val[0] >= $past(cnt_val[0]) && cnt_val[0] <= CNT_MAX)
      else $error("counter 0 went down or past its ceiling");
   priv_read_a: assert property (cmd_valid && op == SAPE_OP_READ && p_private
                                 |=> resp_valid && resp_status == ST_REFUSED)
      else $error("private key read was not refused");
   primary_fixed_a: assert property (cmd_valid && op == SAPE_OP_KEYGEN && cmd_slot == SLOT_PRIMARY
                                     |=> !(grant_valid && !grant_pubkey_only))
      else $error("primary key slot was granted a change");
   locked_regen_a: assert property (cmd_valid && op == SAPE_OP_KEYGEN
                                    && cmd_mode == KEYGEN_MODE_REGEN && !unlocked
                                    |=> resp_status == ST_REFUSED && !grant_valid)
      else $error("locked slot allowed regeneration");
   int_sign_a: assert property (cmd_valid && op == SAPE_OP_SIGN && cmd_slot == SLOT_INT_SIGN
                                && !cmd_internal_msg |=> resp_status == ST_REFUSED)
      else $error("attestation key signed an external message");
   boot_digest_a: assert property (cmd_valid && cmd_slot == SLOT_BOOT_DIGEST
                                   && (op == SAPE_OP_READ || op == SAPE_OP_WRITE)
                                   |=> resp_status == ST_REFUSED)
      else $error("boot digest slot was read or written");
   secret_write_a: assert property (cmd_valid && op == SAPE_OP_WRITE && p_enc_write
                                    && !cmd_encrypted |=> !grant_valid)
      else $error("secret key slot took a clear write");
   lock_stick_a: assert property ((slot_locked_flags & ~$past(slot_locked_flags)) == 16'h0000)
      else $error("a locked slot became unlocked");
   refuse_still_a: assert property (resp_valid && resp_status != ST_OK
                                    |-> slot_locked_flags == $past(slot_locked_flags)
                                        && !grant_valid)
      else $error("refused command changed lock state");

endmodule : sape_engine

// ==== verif/sape_host.sv ====
// host model that issues one command at a time to the engine
module sape_host (
   input  wire logic        clk,
   input  wire logic        resp_valid,
   input  wire logic [1:0]  resp_status,
   input  wire logic [23:0] resp_data,
   output logic             cmd_valid,
   output logic [3:0]       cmd_op,
   output logic [7:0]       cmd_mode,
   output logic [3:0]       cmd_slot,
   output logic [7:0]       cmd_arg,
   output logic [5:0]       fl,
   output logic [3:0]       cmd_write_key
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0]  rs;
   logic [23:0] rd;
   initial begin
      {cmd_valid, cmd_op, cmd_mode, cmd_slot, cmd_arg, fl} = '0;
   end
   assign cmd_write_key = fl[0] ? 4'h6 : 4'h0;
   // ------
   // command cycle: the answer is due exactly one edge after the command
   // ------
   task automatic send(input logic [29:0] w);
      @(negedge clk);
      {cmd_op, cmd_mode, cmd_slot, cmd_arg, fl} = w;
      cmd_valid = 1'b1;
      @(negedge clk);
      cmd_valid = 1'b0;
      // idle fields flip so a stale command is never mistaken for a live one
      {cmd_mode, cmd_slot, cmd_arg} = ~{cmd_mode, cmd_slot, cmd_arg};
      rs = (resp_valid === 1'b1) ? resp_status : 2'bxx;
      rd = resp_data;
   endtask : send
endmodule : sape_host

// ==== verif/sape_engine_tb.sv ====
// self-checking bench for the slot access policy engine
module sape_engine_tb
   import sape_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, reset_n, cmd_valid, resp_valid, gv, gpk, gio, aes_store, boot_latch, vok;
   logic [3:0]  cmd_op, cmd_slot, cmd_write_key, gslot, io_key_slot, gop;
   logic        sbu;
   logic [7:0]  cmd_mode, cmd_arg, spare;
   logic [5:0]  fl;
   logic [1:0]  resp_status, aidx;
   logic [23:0] resp_data;
   logic [15:0] locks;
   int          err_total, num_checks;
   sape_host i_host (.clk(clk), .resp_valid(resp_valid), .resp_status(resp_status),
      .resp_data(resp_data), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_mode(cmd_mode),
      .cmd_slot(cmd_slot), .cmd_arg(cmd_arg), .fl(fl), .cmd_write_key(cmd_write_key));
   sape_engine i_dut (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_mode(cmd_mode), .cmd_slot(cmd_slot), .cmd_arg(cmd_arg), .cmd_internal_msg(fl[5]),
      .cmd_encrypted(fl[4]), .cmd_write_key(cmd_write_key), .cmd_io_protect(fl[3]),
      .cmd_aes_store(fl[2]), .cmd_auth_ok(fl[1]), .resp_valid(resp_valid),
      .resp_status(resp_status), .resp_data(resp_data), .grant_valid(gv), .grant_op(gop),
      .grant_slot(gslot), .grant_pubkey_only(gpk), .grant_io_protect(gio),
      .io_key_slot(io_key_slot), .aes_store(aes_store), .aes_key_index(aidx),
      .slot_locked_flags(locks), .spare_user_byte(spare), .spare_byte_used(sbu),
      .boot_latch(boot_latch), .validated_ok(vok));
   // ------
   // checking and command tasks
   // ------
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic c(input logic [3:0] op, input logic [7:0] md, input logic [3:0] sl,
                    input logic [7:0] ar, input logic [5:0] f, input logic [1:0] st);
      i_host.send({op, md, sl, ar, f});
      chk({22'h0, i_host.rs}, {22'h0, st});
   endtask : c
   task automatic end_sim;
      $display("checks=%0d errors=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      reset_n = 1'b0;
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      chk(24'(locks), 24'h00_FFFF);
      chk(24'(io_key_slot), 24'h00_0006);
      c(4'hC, 8'h00, 4'h0, 8'h54, 6'h00, ST_OK);
      chk(i_host.rd, 24'h00_0000);
      c(4'h8, 8'h00, 4'h0, 8'h5A, 6'h00, ST_OK);
      chk(24'(sbu), 24'h00_0001);
      c(4'h8, 8'h00, 4'h0, 8'hA5, 6'h00, ST_REFUSED);
      chk(24'(spare), 24'h00_005A);
      c(4'h7, 8'h01, 4'h0, 8'h00, 6'h00, ST_OK);
      chk(i_host.rd, 24'h00_0001);
      c(4'h7, 8'h00, 4'h0, 8'h01, 6'h00, ST_OK);
      chk(i_host.rd, 24'h00_0000);
      for (int s = 0; s < 5; s++) begin
         c(4'h0, 8'h00, 4'(s), 8'h00, 6'h00, ST_REFUSED);
      end
      for (int s = 10; s < 13; s++) begin
         c(4'h0, 8'h00, 4'(s), 8'h00, 6'h00, ST_OK);
      end
      c(4'h2, 8'h04, 4'h0, 8'h00, 6'h00, ST_REFUSED);
      c(4'h1, 8'h00, 4'h0, 8'h00, 6'h00, ST_REFUSED);
      c(4'hA, 8'h00, 4'h0, 8'h00, 6'h00, ST_REFUSED);
      c(4'h2, 8'h04, 4'h2, 8'h00, 6'h00, ST_OK);
      c(4'h6, 8'h02, 4'h2, 8'h00, 6'h00, ST_OK);
      chk(24'({gv, gop, gslot}), 24'({1'b1, 4'h6, 4'h2}));
      c(4'h2, 8'h04, 4'h2, 8'h00, 6'h00, ST_REFUSED);
      chk(24'(gv), 24'h00_0000);
      c(4'h6, 8'h00, 4'h8, 8'h00, 6'h00, ST_REFUSED);
      c(4'hD, 8'h00, 4'h0, 8'h00, 6'h00, ST_BAD_CMD);
      c(4'h2, 8'h00, 4'h0, 8'h00, 6'h00, ST_OK);
      chk(24'(gpk), 24'h00_0001);
      c(4'h3, 8'h00, 4'h1, 8'h00, 6'h00, ST_REFUSED);
      c(4'h3, 8'h00, 4'h1, 8'h00, 6'h20, ST_OK);
      c(4'h0, 8'h00, 4'h7, 8'h00, 6'h00, ST_REFUSED);
      c(4'h1, 8'h00, 4'h7, 8'h00, 6'h00, ST_REFUSED);
      c(4'h1, 8'h00, 4'h5, 8'h00, 6'h00, ST_REFUSED);
      c(4'h1, 8'h00, 4'h5, 8'h00, 6'h11, ST_OK);
      c(4'h4, 8'h00, 4'h0, 8'h02, 6'h0C, ST_OK);
      chk(24'({gslot, aidx, aes_store, gio}), 24'({4'h9, 2'h2, 1'b1, 1'b1}));
      c(4'hA, 8'h00, 4'h9, 8'h01, 6'h04, ST_OK);
      chk(24'({gslot, aidx, aes_store, gio}), 24'({4'h9, 2'h1, 1'b1, 1'b0}));
      c(4'h9, 8'h00, 4'hE, 8'h00, 6'h02, ST_REFUSED);
      c(4'h9, 8'h00, 4'hF, 8'h00, 6'h02, ST_OK);
      chk(24'(boot_latch), 24'h00_0001);
      // parent key is written and locked before it validates anything
      c(4'h1, 8'h00, 4'hD, 8'h00, 6'h00, ST_OK);
      c(4'h6, 8'h02, 4'hD, 8'h00, 6'h00, ST_OK);
      c(4'h1, 8'h00, 4'hE, 8'h00, 6'h00, ST_OK);
      c(4'h5, 8'h03, 4'hE, 8'h0D, 6'h02, ST_OK);
      chk(24'(vok), 24'h00_0001);
      c(4'h5, 8'h00, 4'hE, 8'h00, 6'h00, ST_OK);
      c(4'h1, 8'h00, 4'hE, 8'h00, 6'h00, ST_REFUSED);
      c(4'h5, 8'h07, 4'hE, 8'h0D, 6'h02, ST_OK);
      chk(24'(vok), 24'h00_0000);
      c(4'h5, 8'h00, 4'hE, 8'h00, 6'h00, ST_REFUSED);
      // pairing: protection key written, then locked, then challenged
      c(4'h1, 8'h00, 4'h6, 8'h00, 6'h00, ST_OK);
      c(4'h6, 8'h02, 4'h6, 8'h00, 6'h00, ST_OK);
      c(4'hB, 8'h00, 4'h6, 8'h00, 6'h00, ST_OK);
      chk(24'(locks), 24'h00_DFBB);
      c(4'hC, 8'h00, 4'h0, 8'h59, 6'h00, ST_OK);
      chk(i_host.rd, 24'h00_00DF);
      end_sim();
   end
endmodule : sape_engine_tb
